// ---- rtl/qdc_regs.svh ----
/*
 register offsets, field positions, reset values and counts of the
 quad converter serial update block; included by the top and the bench
*/
`ifndef QDC_REGS_SVH
`define QDC_REGS_SVH

// wishbone byte offsets
`define QDC_OFF_CTRL      8'h00
`define QDC_OFF_STATUS    8'h04
`define QDC_OFF_LAST_WORD 8'h08
`define QDC_OFF_CODE_A    8'h10
`define QDC_OFF_CODE_B    8'h14
`define QDC_OFF_CODE_C    8'h18
`define QDC_OFF_CODE_D    8'h1C

// control fields
`define QDC_CTRL_ACCEPT_BIT 0
`define QDC_CTRL_CLEAR_BIT  1
`define QDC_CTRL_RESET      2'h1

// status fields
`define QDC_STAT_TERM_LSB   0
`define QDC_STAT_PD_BIT     2
`define QDC_STAT_VALID_BIT  3
`define QDC_STAT_CNT_LSB    16

// serial word layout
`define QDC_WORD_BITS       16
`define QDC_ADDR_LSB        14
`define QDC_MODE_LSB        12
`define QDC_CODE_BITS       12
`define QDC_CHANNELS        4

// bit counter: last shifting edge and the terminal count
`define QDC_CNT_LAST        5'h0F
`define QDC_CNT_DONE        5'h10

// top serial clock rate the far side may use, in MHz
`define QDC_SCLK_MAX_MHZ    40

`endif

// ---- rtl/qdc_pkg.sv ----
/*
 types of the quad converter serial update block.
 assumes qdc_regs.svh is on the include path.
*/
package qdc_pkg;

    typedef enum logic [1:0]
    {
        QDC_MODE_WRITE  = 2'b00,
        QDC_MODE_UPDATE = 2'b01,
        QDC_MODE_ALL    = 2'b10,
        QDC_MODE_PDOWN  = 2'b11
    } qdc_mode_e;

    typedef enum logic [1:0]
    {
        QDC_TERM_NONE  = 2'b00,
        QDC_TERM_1K    = 2'b01,
        QDC_TERM_100K  = 2'b10,
        QDC_TERM_HIZ   = 2'b11
    } qdc_term_e;

    typedef struct packed
    {
        logic [1:0]  addr;
        qdc_mode_e   mode;
        logic [11:0] code;
    } qdc_word_s;

    typedef struct packed
    {
        logic      down;
        qdc_term_e term;
    } qdc_power_s;

endpackage

// ---- rtl/qdc_sync.sv ----
/*
 two flip-flop level synchroniser into the clk_i domain.
 assumes the input is a level that changes no faster than a few clk_i periods.
*/
`timescale 1ns/100ps

module qdc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // crossing level
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= '0;
            sync_o   <= '0;
        end
        else
        begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end

endmodule

// ---- rtl/qdc_top.sv ----
/*
 serial input and update control of a quad 12-bit converter, with a
 wishbone classic register slave. the serial side runs on its own clock.
 assumes sclk_i only toggles inside frames and frames are spaced apart.
*/
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
// What this block does
// - after frame select falls, one data bit is shifted in per falling serial edge
// - shifting happens only while frame select is low
// - the sixteenth falling edge applies the word and, except in write-only and power-down modes, updates outputs
// - frame select rising before sixteen edges drops the partial word unchanged
// - after reset all codes read zero until an update or update-all word arrives
// - each complete word decodes into address, two-bit mode and 12-bit code; power-down is one of the modes
// - mode selects update of the addressed output or all four together
// - power-down is set by the word, with three output termination choices
// - each of four channels keeps its own 12-bit code from the data field
`timescale 1ns/100ps
`include "qdc_regs.svh"

module qdc_top
    import qdc_pkg::*;
#(
    parameter int CODE_BITS = `QDC_CODE_BITS
) (
    // system clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // wishbone classic slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // serial link
    input  wire logic                 sclk_i,
    input  wire logic                 frame_sel_n_i,
    input  wire logic                 ser_data_i,
    // converter codes and power state
    output logic      [CODE_BITS-1:0] channel_a_output_o,
    output logic      [CODE_BITS-1:0] channel_b_output_o,
    output logic      [CODE_BITS-1:0] channel_c_output_o,
    output logic      [CODE_BITS-1:0] channel_d_output_o,
    output logic                      power_down_o,
    output logic      [1:0]           pd_term_o
);

    // one-hot channel select from the word address
    function automatic logic [3:0] chan_sel(input logic [1:0] addr);
        chan_sel = 4'h1 << addr;
    endfunction

    // termination from the address field while powering down
    function automatic qdc_term_e term_of(input logic [1:0] addr);
        case (addr)
            2'b00:   term_of = QDC_TERM_1K;
            2'b01:   term_of = QDC_TERM_100K;
            default: term_of = QDC_TERM_HIZ;
        endcase
    endfunction

    // link domain
    logic [4:0]                  bit_cnt_reg;
    logic [`QDC_WORD_BITS-1:0]   shift_reg;
    logic [`QDC_WORD_BITS-1:0]   link_word_reg;
    logic                        link_tog_reg;

    // system domain
    logic                        tog_sync;
    logic                        tog_seen_reg;
    logic                        word_evt;
    logic                        apply;
    qdc_word_s                   rx_word;
    logic [3:0]                  sel;
    logic [CODE_BITS-1:0]        in_reg  [`QDC_CHANNELS];
    logic [CODE_BITS-1:0]        in_next [`QDC_CHANNELS];
    logic [CODE_BITS-1:0]        dac_reg [`QDC_CHANNELS];
    qdc_power_s                  pwr_reg;
    logic                        valid_seen_reg;
    logic [15:0]                 word_cnt_reg;
    logic [`QDC_WORD_BITS-1:0]   last_word_reg;
    logic                        accept_reg;
    logic                        clear_reg;
    logic                        bus_req;
    logic                        bus_wr;
    logic [31:0]                 rd_next;

    // frame select high holds the counter at zero, which both aborts a
    // partial word and restarts each frame; sclk is idle between frames
    always_ff @(negedge sclk_i or posedge frame_sel_n_i)
    begin
        if (frame_sel_n_i)
        begin
            bit_cnt_reg <= 5'h00;
            shift_reg   <= '0;
        end
        else if (bit_cnt_reg != `QDC_CNT_DONE)
        begin
            shift_reg   <= {shift_reg[`QDC_WORD_BITS-2:0], ser_data_i};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    // capture on the sixteenth edge; the word then stays put until the sixteenth
    // edge of the next frame, long enough for the toggle to cross and be sampled
    always_ff @(negedge sclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            link_word_reg <= '0;
            link_tog_reg  <= 1'b0;
        end
        else if (!frame_sel_n_i && bit_cnt_reg == `QDC_CNT_LAST)
        begin
            link_word_reg <= {shift_reg[`QDC_WORD_BITS-2:0], ser_data_i};
            link_tog_reg  <= ~link_tog_reg;
        end
    end

    qdc_sync #(
        .WIDTH (1)
    ) u_tog_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (link_tog_reg),
        .sync_o  (tog_sync)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tog_seen_reg <= 1'b0;
        else
            tog_seen_reg <= tog_sync;
    end

    // link word is stable while the toggle edge is seen; safe at 40 MHz max
    assign word_evt = tog_sync ^ tog_seen_reg;
    assign rx_word  = qdc_word_s'(link_word_reg);
    assign apply    = word_evt & accept_reg;
    assign sel      = chan_sel(rx_word.addr);

    // per-channel input and output code holding
    genvar ch;
    generate
        for (ch = 0; ch < `QDC_CHANNELS; ch = ch + 1)
        begin : g_chan
            always_comb
            begin
                in_next[ch] = in_reg[ch];
                if (apply && rx_word.mode != QDC_MODE_PDOWN && sel[ch])
                    in_next[ch] = rx_word.code[CODE_BITS-1:0];
            end

            always_ff @(posedge clk_i)
            begin
                if (rst_i || clear_reg)
                    in_reg[ch] <= '0;
                else
                    in_reg[ch] <= in_next[ch];
            end

            always_ff @(posedge clk_i)
            begin
                if (rst_i || clear_reg)
                    dac_reg[ch] <= '0;
                else if (apply)
                begin
                    case (rx_word.mode)
                        QDC_MODE_UPDATE:
                            if (sel[ch])
                                dac_reg[ch] <= in_next[ch];
                        QDC_MODE_ALL:
                            dac_reg[ch] <= in_next[ch];
                        default:
                            dac_reg[ch] <= dac_reg[ch];
                    endcase
                end
            end
        end
    endgenerate

    assign channel_a_output_o = dac_reg[0];
    assign channel_b_output_o = dac_reg[1];
    assign channel_c_output_o = dac_reg[2];
    assign channel_d_output_o = dac_reg[3];

    // power state: updating words wake the outputs, write-only keeps it
    always_ff @(posedge clk_i)
    begin
        if (rst_i || clear_reg)
            pwr_reg <= '{down: 1'b0, term: QDC_TERM_NONE};
        else if (apply)
        begin
            case (rx_word.mode)
                QDC_MODE_PDOWN:
                    pwr_reg <= '{down: 1'b1, term: term_of(rx_word.addr)};
                QDC_MODE_UPDATE,
                QDC_MODE_ALL:
                    pwr_reg <= '{down: 1'b0, term: QDC_TERM_NONE};
                default:
                    pwr_reg <= pwr_reg;
            endcase
        end
    end

    assign power_down_o = pwr_reg.down;
    assign pd_term_o    = pwr_reg.term;

    // bookkeeping seen by software
    always_ff @(posedge clk_i)
    begin
        // a word landing together with a clear still counts as seen
        if (rst_i)
            valid_seen_reg <= 1'b0;
        else if (apply)
            valid_seen_reg <= 1'b1;
        else if (clear_reg)
            valid_seen_reg <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            word_cnt_reg  <= 16'h0000;
            last_word_reg <= '0;
        end
        else if (word_evt)
        begin
            word_cnt_reg  <= word_cnt_reg + 16'h0001;
            last_word_reg <= link_word_reg;
        end
    end

    // wishbone classic: ack one cycle after the request, dropped after one
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_wr  = bus_req & wb_we_i & wb_ack_o;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req & ~wb_ack_o;
    end

    // writes land at the edge where ack is sampled high
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            accept_reg <= 1'(`QDC_CTRL_RESET);
            clear_reg  <= 1'b0;
        end
        else if (bus_wr && wb_adr_i == `QDC_OFF_CTRL && wb_sel_i[0])
        begin
            accept_reg <= wb_dat_i[`QDC_CTRL_ACCEPT_BIT];
            clear_reg  <= wb_dat_i[`QDC_CTRL_CLEAR_BIT];
        end
        else
            clear_reg  <= 1'b0;
    end

    always_comb
    begin
        rd_next = 32'h0000_0000;
        case (wb_adr_i)
            `QDC_OFF_CTRL:
                rd_next[`QDC_CTRL_ACCEPT_BIT] = accept_reg;
            `QDC_OFF_STATUS:
            begin
                rd_next[`QDC_STAT_TERM_LSB +: 2] = pwr_reg.term;
                rd_next[`QDC_STAT_PD_BIT]        = pwr_reg.down;
                rd_next[`QDC_STAT_VALID_BIT]     = valid_seen_reg;
                rd_next[`QDC_STAT_CNT_LSB +: 16] = word_cnt_reg;
            end
            `QDC_OFF_LAST_WORD:
                rd_next[`QDC_WORD_BITS-1:0] = last_word_reg;
            `QDC_OFF_CODE_A:
                rd_next[CODE_BITS-1:0] = dac_reg[0];
            `QDC_OFF_CODE_B:
                rd_next[CODE_BITS-1:0] = dac_reg[1];
            `QDC_OFF_CODE_C:
                rd_next[CODE_BITS-1:0] = dac_reg[2];
            `QDC_OFF_CODE_D:
                rd_next[CODE_BITS-1:0] = dac_reg[3];
            default:
                rd_next = 32'h0000_0000;
        endcase
    end

    // read data is captured with the request and holds through the ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (bus_req && !wb_ack_o)
            wb_dat_o <= rd_next;
    end

endmodule

// ---- testbench/qdc_top_asserts.sv ----
/*
 port assertions of the quad converter serial update top.
 assumes it is bound into qdc_top, clk_i domain only.
*/
`timescale 1ns/100ps

module qdc_top_asserts #(
    parameter int CODE_BITS = 12
) (
    // system side
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire logic [7:0]           wb_adr_i,
    input wire logic [31:0]          wb_dat_o,
    input wire logic                 wb_ack_o,
    // link and outputs
    input wire logic                 frame_sel_n_i,
    input wire logic [CODE_BITS-1:0] channel_a_output_o,
    input wire logic [CODE_BITS-1:0] channel_b_output_o,
    input wire logic [CODE_BITS-1:0] channel_c_output_o,
    input wire logic [CODE_BITS-1:0] channel_d_output_o,
    input wire logic                 power_down_o,
    input wire logic [1:0]           pd_term_o
);
    logic [4*CODE_BITS-1:0] codes;
    assign codes = {channel_a_output_o, channel_b_output_o,
                    channel_c_output_o, channel_d_output_o};
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_reset_zero;
        $fell(rst_i) |-> codes == '0 && !power_down_o && pd_term_o == 2'h0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("codes not zero");
    // codes move only three cycles after a frame's word, or after a bus clear
    property p_code_hold;
        $changed(codes) |-> !$past(frame_sel_n_i, 4)
            || ($past(wb_ack_o, 2) && $past(wb_we_i, 2));
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("code moved in frame");
    property p_power_hold;
        $changed({power_down_o, pd_term_o}) |-> !$past(frame_sel_n_i, 4)
            || ($past(wb_ack_o, 2) && $past(wb_we_i, 2));
    endproperty
    a_power_hold: assert property (p_power_hold) else $error("power moved in frame");
    property p_pd_term;
        power_down_o |-> pd_term_o != 2'h0;
    endproperty
    a_pd_term: assert property (p_pd_term) else $error("no termination");
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    property p_unmapped;
        wb_ack_o && !wb_we_i && wb_adr_i > 8'h1C |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule

bind qdc_top qdc_top_asserts #(.CODE_BITS(CODE_BITS)) i_qdc_top_asserts (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .frame_sel_n_i, .channel_a_output_o, .channel_b_output_o, .channel_c_output_o,
    .channel_d_output_o, .power_down_o, .pd_term_o);

// ---- testbench/qdc_ser_host.sv ----
/*
 serial controller model: frame select, clock and data.
 assumes send is called between frames only.
*/
`timescale 1ns/100ps

module qdc_ser_host (
    // serial link toward the block
    output logic sclk_o,
    output logic frame_sel_n_o,
    output logic ser_data_o
);
    // clock idles high, so no stray falling edge outside frames
    initial
    begin
        sclk_o = 1'b1;
        frame_sel_n_o = 1'b1;
        ser_data_o = 1'b0;
    end

    // n below 16 aborts; extra edges past 16 must be ignored
    task automatic send(input logic [15:0] w, input int n, input int extra);
        #7;
        frame_sel_n_o = 1'b0;
        for (int i = 0; i < n + extra; i++)
        begin
            ser_data_o = (i < 16) ? w[15-i] : ~ser_data_o;
            #16 sclk_o = 1'b0;
            #16 sclk_o = 1'b1;
        end
        #8 frame_sel_n_o = 1'b1;
        ser_data_o = ~ser_data_o;
        #200;
    endtask
endmodule

// ---- testbench/tb_top.sv ----
/*
 self-checking bench of the quad converter serial update top.
 assumes qdc_regs.svh on the include path and the serial model beside it.
*/
`timescale 1ns/100ps
`include "qdc_regs.svh"

module tb_top
    import qdc_pkg::*;
;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        sclk_i, frame_sel_n_i, ser_data_i, power_down_o, pd, acc;
    logic [11:0] ch_o [4];
    logic [11:0] inp [4];
    logic [11:0] outv [4];
    logic [1:0]  pd_term_o, term;
    logic [15:0] last;
    logic [50:0] prev_outs;
    logic [31:0] rd_q [$];
    logic [50:0] out_q [$];
    int          fails, samples_checked, cnt, seed;
    wire  [50:0] outs = {ch_o[0], ch_o[1], ch_o[2], ch_o[3], power_down_o, pd_term_o};

    qdc_top i_qdc_top (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .sclk_i, .frame_sel_n_i, .ser_data_i,
        .channel_a_output_o(ch_o[0]), .channel_b_output_o(ch_o[1]),
        .channel_c_output_o(ch_o[2]), .channel_d_output_o(ch_o[3]),
        .power_down_o, .pd_term_o);
    qdc_ser_host i_qdc_ser_host (
        .sclk_o(sclk_i), .frame_sel_n_o(frame_sel_n_i), .ser_data_o(ser_data_i));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    function automatic logic [50:0] model_outs();
        return {outv[0], outv[1], outv[2], outv[3], pd, term};
    endfunction

    task automatic check(input string nm, input logic [50:0] got, input logic [50:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= we ? 4'hF : 4'($random(seed));
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && ++n < 50);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50)
        begin
            fails++;
            conclude();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(a, 1'b0, e);
    endtask

    // reference model runs before the frame, so the note waits in the queue
    task automatic frame(input logic [15:0] w, input int n, input int extra);
        qdc_word_s   s;
        logic [50:0] old;
        s = w;
        old = model_outs();
        if (n == 16) cnt++;
        if (n == 16) last = w;
        if (n == 16 && acc)
        begin
            if (s.mode != QDC_MODE_PDOWN) inp[s.addr] = s.code;
            if (s.mode == QDC_MODE_UPDATE) outv[s.addr] = s.code;
            if (s.mode == QDC_MODE_ALL) outv = inp;
            if (s.mode == QDC_MODE_PDOWN) term = 2'h1 + 2'(s.addr != 2'h0) + 2'(s.addr[1]);
            if (s.mode != QDC_MODE_WRITE) pd = s.mode == QDC_MODE_PDOWN;
            if (!pd) term = 2'h0;
        end
        if (model_outs() !== old) out_q.push_back(model_outs());
        i_qdc_ser_host.send(w, n, extra);
    endtask

    always @(posedge clk_i)
    begin
        prev_outs <= outs;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            check("read", wb_dat_o, rd_q.size() ? rd_q.pop_front() : ~wb_dat_o);
        if (rst_i === 1'b0 && outs !== prev_outs)
            check("outs", outs, out_q.size() ? out_q.pop_front() : ~outs);
    end

    initial
    begin
        #300000;
        fails++;
        conclude();
    end

    initial
    begin
        seed = 1;
        {fails, samples_checked, cnt} = '0;
        {acc, pd, term, last} = {1'b1, 19'h0_0000};
        for (int k = 0; k < 4; k++) {inp[k], outv[k]} = 24'h00_0000;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`QDC_OFF_CTRL, 32'h0000_0001);
        rd(`QDC_OFF_STATUS, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        // every mode on every address, with surplus edges on some
        for (int i = 0; i < 16; i++)
            frame({i[1:0], i[3:2], 12'($random(seed))}, 16, i % 3);
        frame(16'h6ABC, 7, 0);
        frame(16'h6ABC, 15, 0);
        frame(16'h9123, 16, 0);
        wb(`QDC_OFF_CTRL, 1'b1, 32'h0000_0000);
        acc = 1'b0;
        frame(16'h5555, 16, 0);
        acc = 1'b1;
        wb(`QDC_OFF_CTRL, 1'b1, 32'h0000_0001);
        wb(`QDC_OFF_CODE_A, 1'b1, 32'hFFFF_FFFF);
        for (int k = 0; k < 4; k++)
            rd(`QDC_OFF_CODE_A + 8'(4 * k), {20'h0_0000, outv[k]});
        rd(`QDC_OFF_STATUS, {16'(cnt), 12'h000, 1'b1, pd, term});
        rd(`QDC_OFF_LAST_WORD, {16'h0000, last});
        for (int k = 0; k < 4; k++) {inp[k], outv[k]} = 24'h00_0000;
        {pd, term} = 3'h0;
        out_q.push_back(51'h0);
        wb(`QDC_OFF_CTRL, 1'b1, 32'h0000_0003);
        frame(16'hA7E5, 16, 0);
        repeat (10) @(posedge clk_i);
        check("pending", 51'(out_q.size()), 51'h0);
        conclude();
    end
endmodule
